// >>> common/cdr_defines.svh
// register offsets, field positions, reset values and lock figures
// included only by the acquisition controller, cdr_acq_ctl
`ifndef CDR_DEFINES_SVH
`define CDR_DEFINES_SVH
`define CDR_ADDR_LOOP    8'h10
`define CDR_ADDR_DETAIL  8'h13
`define CDR_ADDR_PHASE   8'h14
`define CDR_ADDR_SLICE   8'h15
`define CDR_ADDR_TRIM    8'h73
`define CDR_RST_LOOP     8'h04
`define CDR_RST_DETAIL   8'h82
`define CDR_RST_PHASE    8'h00
`define CDR_RST_SLICE    8'h40
`define CDR_EDGE_HI      4
`define CDR_EDGE_LO      3
`define CDR_BW_HI        2
`define CDR_SLEW_HI      1
`define CDR_ADAPT_BIT    7
`define CDR_PHASE_HI     3
`define CDR_SLICE_HI     6
`define CDR_EXT_BIT      7
`define CDR_EDGE_RISE    2'h1
`define CDR_EDGE_FALL    2'h2
`define CDR_SLICE_OFF    7'h00
`define CDR_SLICE_ZERO   8'h40
`define CDR_LOCK_PPM     250
`define CDR_UNLOCK_PPM   1000
`define CDR_PPM_SCALE    1000000
`define CDR_N_MIN        3'h0
`endif

// >>> common/cdr_pkg.sv
// types shared by the acquisition controller and its register port
// assumes cdr_defines.svh is on the include path
package cdr_pkg;
  // gray-coded along start -> measure -> track
  typedef enum logic [1:0] {
    st_start   = 2'b00,
    st_measure = 2'b01,
    st_track   = 2'b11
  } cdr_acq_state_t;
  typedef enum logic [2:0] {
    i2c_idle = 3'b000, i2c_addr = 3'b001, i2c_aack = 3'b011, i2c_wdata = 3'b010,
    i2c_wack = 3'b110, i2c_rdata = 3'b111, i2c_rack = 3'b101
  } cdr_i2c_state_t;
endpackage

// >>> core/cdr_acq_ctl.sv
// frequency acquisition, slice offset and phase-loop tuning of the cdr
// assumes tick and detector inputs are single-cycle pulses on clock_i
// Overview of operation
// - over 1000 ppm error raises loss of lock and restarts acquisition
// - each acquisition starts with oscillator at bottom and N equal one
// - sampling faster doubles N; data faster raises the oscillator
// - steps start large, shrink near target; lock flag drops within 250 ppm
// - once locked, frequency loop stops and phase loops pull the oscillator
// - threshold offset code is bits 6..0 of the threshold register
// - normal mode: 0 off, 1 lowest, 64 zero, 127 highest, linear
// - bit 7 set widens the threshold range six times
// - factory trimmed offset reads back as seven bits at 0x73
// - edge field 1 uses rising edges only, 2 falling edges only
// - slew field, default 2, sets delay-loop tracking (1+value)/4 UI
// - signed 4-bit field shifts sampling instant in 1/32 UI steps
// - bandwidth field defaults to 4, bandwidth scales by value/4
// - one phase detector drives both tracking loops at every N
`timescale 1ns/1ps
`include "cdr_defines.svh"
module cdr_acq_ctl import cdr_pkg::*; #(
  parameter int         CODE_W   = 10,
  parameter int         WIN_BITS = 14,
  parameter int         DLL_W    = 8,
  parameter logic [2:0] N_MAX    = 3'h7,
  // two-wire address value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // two-wire register port
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  // factory trim
  input  wire logic [6:0]        trim_offset_i,
  // frequency measurement
  input  wire logic              sample_tick_i,
  input  wire logic              data_tick_i,
  // shared binary phase detector
  input  wire logic              pd_early_i,
  input  wire logic              pd_late_i,
  input  wire logic              pd_rise_i,
  // acquisition outputs
  output logic                   loss_of_lock_flag_o,
  output logic [CODE_W-1:0]      controlled_oscillator_o,
  output logic [2:0]             div_exp_o,
  output logic                   fll_active_o,
  // tracking loop outputs
  output logic [DLL_W-1:0]       dll_phase_o,
  output logic [1:0]             edge_sel_o,
  output logic [1:0]             dll_slew_o,
  output logic signed [3:0]      sample_phase_o,
  output logic [2:0]             transfer_bandwidth_scale_o,
  // quantizer threshold outputs
  output logic                   slice_enable_o,
  output logic                   slice_extended_o,
  output logic signed [7:0]      slice_step_o,
  output logic                   adaptive_slice_o
);
  localparam int DW = WIN_BITS + 2;
  localparam logic [DW-1:0] LOCK_CNT =
    DW'((2 ** WIN_BITS) * `CDR_LOCK_PPM / `CDR_PPM_SCALE);
  localparam logic [DW-1:0] UNLOCK_CNT =
    DW'((2 ** WIN_BITS) * `CDR_UNLOCK_PPM / `CDR_PPM_SCALE);
  localparam logic [CODE_W-1:0] STEP_INIT = CODE_W'(2 ** (CODE_W - 2));
  localparam logic [CODE_W-1:0] CODE_MAX  = {CODE_W{1'b1}};

  // register file
  logic [7:0] loop_edge_and_bandwidth_reg;
  logic [7:0] loop_detail_config_reg;
  logic [7:0] sampling_instant_adjust_reg;
  logic [7:0] quantizer_threshold_control_reg;
  logic [7:0] trimmed_offset_readback_reg;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr_stb;
  logic [7:0] reg_rdata;

  // acquisition
  cdr_acq_state_t    state_reg;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] step_reg;
  logic [2:0]        div_exp_reg;
  logic              raised_reg;
  logic              lol_reg;
  logic              meas_start_reg;
  logic              meas_valid;
  logic signed [DW-1:0] meas_diff;
  logic [DW-1:0]     meas_abs;
  logic              pd_take;
  logic [CODE_W-1:0] pll_gain;
  logic [DLL_W-1:0]  dll_step;

  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    case (addr)
      `CDR_ADDR_LOOP:   reg_read = loop_edge_and_bandwidth_reg;
      `CDR_ADDR_DETAIL: reg_read = loop_detail_config_reg;
      `CDR_ADDR_PHASE:  reg_read = sampling_instant_adjust_reg;
      `CDR_ADDR_SLICE:  reg_read = quantizer_threshold_control_reg;
      `CDR_ADDR_TRIM:   reg_read = trimmed_offset_readback_reg;
      default:          reg_read = 8'h00;
    endcase
  endfunction

  // phase errors counted on rising edges only for edge field 1, falling only for 2, both for 0 and 3
  function automatic logic edge_ok(input logic [1:0] sel, input logic rise);
    case (sel)
      `CDR_EDGE_RISE: edge_ok = rise;
      `CDR_EDGE_FALL: edge_ok = ~rise;
      default:        edge_ok = 1'b1;
    endcase
  endfunction

  assign reg_rdata = reg_read(reg_addr);
  assign meas_abs  = meas_diff[DW-1] ? DW'(-meas_diff) : DW'(meas_diff);

  cdr_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .reg_addr_o (reg_addr),
    .wdata_o    (reg_wdata),
    .wr_stb_o   (reg_wr_stb),
    .rdata_i    (reg_rdata)
  );

  cdr_freq_meter #(
    .WIN_BITS (WIN_BITS)
  ) u_meter (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .start_i       (meas_start_reg),
    .sample_tick_i (sample_tick_i),
    .data_tick_i   (data_tick_i),
    .meas_valid_o  (meas_valid),
    .meas_diff_o   (meas_diff)
  );

  // software-written configuration
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      loop_edge_and_bandwidth_reg     <= `CDR_RST_LOOP;
      loop_detail_config_reg          <= `CDR_RST_DETAIL;
      sampling_instant_adjust_reg     <= `CDR_RST_PHASE;
      quantizer_threshold_control_reg <= `CDR_RST_SLICE;
    end else if (ce_i && reg_wr_stb) begin
      case (reg_addr)
        `CDR_ADDR_LOOP:   loop_edge_and_bandwidth_reg     <= reg_wdata;
        `CDR_ADDR_DETAIL: loop_detail_config_reg          <= reg_wdata;
        `CDR_ADDR_PHASE:  sampling_instant_adjust_reg     <= reg_wdata;
        `CDR_ADDR_SLICE:  quantizer_threshold_control_reg <= reg_wdata;
        default:          ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i)
      trimmed_offset_readback_reg <= 8'h00;
    else if (ce_i)
      trimmed_offset_readback_reg <= {1'b0, trim_offset_i};
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg      <= st_start;
      code_reg       <= '0;
      step_reg       <= STEP_INIT;
      div_exp_reg    <= `CDR_N_MIN;
      raised_reg     <= 1'b0;
      lol_reg        <= 1'b1;
      meas_start_reg <= 1'b1;
    end else if (ce_i) begin
      meas_start_reg <= 1'b0;
      case (state_reg)
        st_start: begin
          code_reg       <= '0;
          step_reg       <= STEP_INIT;
          div_exp_reg    <= `CDR_N_MIN;
          raised_reg     <= 1'b0;
          lol_reg        <= 1'b1;
          meas_start_reg <= 1'b1;
          state_reg      <= st_measure;
        end
        st_measure: begin
          if (meas_valid) begin
            meas_start_reg <= 1'b1;
            if (meas_abs <= LOCK_CNT) begin
              lol_reg   <= 1'b0;
              state_reg <= st_track;
            end else if (!meas_diff[DW-1]) begin
              // overshoot backs off and halves the step
              if (raised_reg) begin
                code_reg <= code_reg - step_reg;
                if (step_reg > CODE_W'(1))
                  step_reg <= step_reg >> 1;
              end else if (div_exp_reg == N_MAX) begin
                state_reg <= st_start;
              end else begin
                div_exp_reg <= div_exp_reg + 3'h1;
              end
            end else if (code_reg > CODE_MAX - step_reg) begin
              // shrink before giving up
              if (step_reg > CODE_W'(1))
                step_reg <= step_reg >> 1;
              else
                state_reg <= st_start;
            end else begin
              code_reg   <= code_reg + step_reg;
              raised_reg <= 1'b1;
            end
          end
        end
        st_track: begin
          if (meas_valid && meas_abs > UNLOCK_CNT) begin
            lol_reg   <= 1'b1;
            state_reg <= st_start;
          end else if (pd_take && pd_late_i && !pd_early_i) begin
            code_reg <= (code_reg > CODE_MAX - pll_gain) ? CODE_MAX
                                                         : code_reg + pll_gain;
          end else if (pd_take && pd_early_i && !pd_late_i) begin
            code_reg <= (code_reg < pll_gain) ? '0 : code_reg - pll_gain;
          end
        end
        default: state_reg <= st_start;
      endcase
    end
  end

  assign pd_take = edge_ok(loop_edge_and_bandwidth_reg[`CDR_EDGE_HI:`CDR_EDGE_LO],
                           pd_rise_i);
  // integral gain follows bandwidth field; zero leaves loop open
  assign pll_gain = CODE_W'(loop_edge_and_bandwidth_reg[`CDR_BW_HI:0]);
  // delay-loop step is one plus slew
  assign dll_step = DLL_W'(loop_detail_config_reg[`CDR_SLEW_HI:0]) + DLL_W'(1);

  // same detector drives the delay loop at every division rate
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dll_phase_o <= '0;
    end else if (ce_i && pd_take && (pd_early_i ^ pd_late_i)) begin
      // phase shifter has no end stops, so wrapping is intended
      if (pd_late_i)
        dll_phase_o <= dll_phase_o - dll_step;
      else
        dll_phase_o <= dll_phase_o + dll_step;
    end
  end

  // registered acquisition and tuning outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      loss_of_lock_flag_o        <= 1'b1;
      controlled_oscillator_o    <= '0;
      div_exp_o                  <= `CDR_N_MIN;
      fll_active_o               <= 1'b1;
      edge_sel_o                 <= 2'(`CDR_RST_LOOP >> `CDR_EDGE_LO);
      dll_slew_o                 <= 2'(`CDR_RST_DETAIL);
      sample_phase_o             <= 4'(`CDR_RST_PHASE);
      transfer_bandwidth_scale_o <= 3'(`CDR_RST_LOOP);
    end else if (ce_i) begin
      loss_of_lock_flag_o        <= lol_reg;
      controlled_oscillator_o    <= code_reg;
      div_exp_o                  <= div_exp_reg;
      fll_active_o               <= (state_reg != st_track);
      edge_sel_o                 <= loop_edge_and_bandwidth_reg[`CDR_EDGE_HI:`CDR_EDGE_LO];
      dll_slew_o                 <= loop_detail_config_reg[`CDR_SLEW_HI:0];
      sample_phase_o             <= $signed(sampling_instant_adjust_reg[`CDR_PHASE_HI:0]);
      transfer_bandwidth_scale_o <= loop_edge_and_bandwidth_reg[`CDR_BW_HI:0];
    end
  end

  // quantizer threshold outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      slice_enable_o   <= 1'b1;
      slice_extended_o <= 1'b0;
      slice_step_o     <= '0;
      adaptive_slice_o <= 1'b1;
    end else if (ce_i) begin
      // code zero disables, 64 is centre
      slice_enable_o <= (quantizer_threshold_control_reg[`CDR_SLICE_HI:0] != `CDR_SLICE_OFF);
      slice_step_o   <= $signed({1'b0, quantizer_threshold_control_reg[`CDR_SLICE_HI:0]})
                        - $signed(`CDR_SLICE_ZERO);
      slice_extended_o <= quantizer_threshold_control_reg[`CDR_EXT_BIT];
      // dc offset loop overrides manual code while enabled
      adaptive_slice_o <= loop_detail_config_reg[`CDR_ADAPT_BIT];
    end
  end
endmodule // cdr_acq_ctl

// >>> core/cdr_freq_meter.sv
// counts divided sampling ticks over a window of 2**WIN_BITS data ticks
// assumes both tick inputs are one-cycle pulses synchronous to clock_i
`timescale 1ns/1ps
module cdr_freq_meter import cdr_pkg::*; #(
  parameter int WIN_BITS = 14
) (
  // clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // measurement
  input  wire logic                       start_i,
  input  wire logic                       sample_tick_i,
  input  wire logic                       data_tick_i,
  output logic                            meas_valid_o,
  output logic signed [WIN_BITS+1:0]      meas_diff_o
);
  logic [WIN_BITS-1:0] data_cnt_reg;
  logic [WIN_BITS:0]   samp_cnt_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_cnt_reg <= '0;
      samp_cnt_reg <= '0;
      meas_valid_o <= 1'b0;
      meas_diff_o  <= '0;
    end else if (ce_i) begin
      meas_valid_o <= 1'b0;
      if (start_i) begin
        data_cnt_reg <= '0;
        samp_cnt_reg <= '0;
      end else begin
        // saturate so a far-too-fast oscillator still reads as fast
        if (sample_tick_i && !(&samp_cnt_reg))
          samp_cnt_reg <= samp_cnt_reg + 1'b1;
        if (data_tick_i) begin
          data_cnt_reg <= data_cnt_reg + 1'b1;
          if (&data_cnt_reg) begin
            meas_valid_o <= 1'b1;
            meas_diff_o  <= $signed({1'b0, samp_cnt_reg}) -
                            $signed({2'b01, {WIN_BITS{1'b0}}});
            samp_cnt_reg <= '0;
          end
        end
      end
    end
  end
endmodule // cdr_freq_meter

// >>> core/cdr_i2c_slave.sv
// two-wire slave: pointer byte, then auto-incremented writes or reads
// assumes scl_i and sda_i already synchronous and much slower than clock_i
`timescale 1ns/1ps
module cdr_i2c_slave import cdr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // register side
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_stb_o,
  input  wire logic [7:0] rdata_i
);
  cdr_i2c_state_t state_reg;
  logic [7:0]     shift_reg;
  logic [2:0]     bit_reg;
  logic           scl_q, sda_q, rw_reg, ptr_reg, nack_reg, armed_reg;
  logic           scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= i2c_idle;
      {shift_reg, bit_reg, rw_reg, ptr_reg, nack_reg, armed_reg} <= '0;
      {reg_addr_o, wdata_o, wr_stb_o, sda_o, sda_oe_o} <= '0;
    end else if (ce_i) begin
      wr_stb_o <= 1'b0;
      sda_o    <= 1'b0;
      if (start_c) begin
        state_reg <= i2c_addr;
        bit_reg   <= '0;
        armed_reg <= 1'b0;
        sda_oe_o  <= 1'b0;
      end else if (stop_c) begin
        state_reg <= i2c_idle;
        sda_oe_o  <= 1'b0;
      end else if (scl_rise) begin
        armed_reg <= 1'b1;
        if (state_reg == i2c_addr || state_reg == i2c_wdata)
          shift_reg <= {shift_reg[6:0], sda_i};
        if (state_reg == i2c_rack)
          nack_reg <= sda_i;
      end else if (scl_fall) begin
        case (state_reg)
          // the fall closing a start carries no bit
          i2c_addr: if (armed_reg) begin
            bit_reg <= bit_reg + 1'b1;
            if (&bit_reg) begin
              state_reg <= (shift_reg[7:1] == DEV_ADDR) ? i2c_aack : i2c_idle;
              sda_oe_o  <= (shift_reg[7:1] == DEV_ADDR);
              rw_reg    <= shift_reg[0];
            end
          end
          i2c_aack, i2c_wack: begin
            bit_reg  <= '0;
            ptr_reg  <= (state_reg == i2c_aack) | ptr_reg;
            sda_oe_o <= 1'b0;
            state_reg <= i2c_wdata;
            if (rw_reg) begin
              state_reg <= i2c_rdata;
              shift_reg <= rdata_i;
              sda_oe_o  <= ~rdata_i[7];
            end
          end
          i2c_wdata: begin
            bit_reg <= bit_reg + 1'b1;
            if (&bit_reg) begin
              state_reg <= i2c_wack;
              sda_oe_o  <= 1'b1;
              ptr_reg   <= 1'b0;
              if (ptr_reg)
                reg_addr_o <= shift_reg;
              else begin
                wdata_o  <= shift_reg;
                wr_stb_o <= 1'b1;
              end
            end
          end
          i2c_rdata: begin
            bit_reg   <= bit_reg + 1'b1;
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe_o  <= ~shift_reg[6] & ~(&bit_reg);
            if (&bit_reg) begin
              state_reg  <= i2c_rack;
              reg_addr_o <= reg_addr_o + 1'b1;
            end
          end
          i2c_rack: begin
            state_reg <= nack_reg ? i2c_idle : i2c_aack;
          end
          default: state_reg <= i2c_idle;
        endcase
      end
      // write pointer advances after each stored data byte
      if (wr_stb_o)
        reg_addr_o <= reg_addr_o + 1'b1;
    end
  end
endmodule // cdr_i2c_slave

// >>> tb/cdr_acq_ctl_properties.sv
// port assertions of the acquisition controller
// bound to cdr_acq_ctl; assumes ce_i is held high
`timescale 1ns/1ps
module cdr_acq_ctl_properties #(
  parameter int CODE_W = 10,
  parameter int DLL_W  = 8
) (
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire logic              pd_early_i,
  input wire logic              pd_late_i,
  input wire logic              loss_of_lock_flag_o,
  input wire logic [CODE_W-1:0] controlled_oscillator_o,
  input wire logic [2:0]        div_exp_o,
  input wire logic              fll_active_o,
  input wire logic [DLL_W-1:0]  dll_phase_o,
  input wire logic [1:0]        dll_slew_o,
  input wire logic [2:0]        transfer_bandwidth_scale_o,
  input wire logic signed [7:0] slice_step_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [DLL_W-1:0] dll_step;
  assign dll_step = DLL_W'(dll_slew_o) + DLL_W'(1);
  sequence s_unlock;
    $rose(loss_of_lock_flag_o);
  endsequence
  sequence s_bottom;
    ##[0:2] (controlled_oscillator_o == '0 && div_exp_o == 3'h0);
  endsequence
  a_reset_values: assert property (
    $fell(rst_i) |-> loss_of_lock_flag_o && fll_active_o && div_exp_o == 3'h0
      && transfer_bandwidth_scale_o == 3'h4 && dll_slew_o == 2'h2)
    else $error("reset values wrong");
  a_lock_stops_fll: assert property (
    !loss_of_lock_flag_o |-> !fll_active_o) else $error("frequency loop on while locked");
  a_restart_bottom: assert property (
    s_unlock |-> s_bottom) else $error("restart not at bottom");
  a_div_doubles: assert property (
    div_exp_o != $past(div_exp_o) && div_exp_o != 3'h0 |-> div_exp_o == $past(div_exp_o) + 3'h1)
    else $error("division skipped an octave");
  a_track_div_frozen: assert property (
    !fll_active_o && !$past(fll_active_o) |-> $stable(div_exp_o))
    else $error("division moved while tracking");
  a_dll_late_step: assert property (
    pd_late_i && !pd_early_i |=> dll_phase_o == $past(dll_phase_o) - $past(dll_step))
    else $error("late pulse step wrong");
  a_dll_early_step: assert property (
    pd_early_i && !pd_late_i |=> dll_phase_o == $past(dll_phase_o) + $past(dll_step))
    else $error("early pulse step wrong");
  a_dll_no_step: assert property (
    pd_early_i == pd_late_i |=> $stable(dll_phase_o)) else $error("phase moved without pulse");
  a_slice_range: assert property (
    slice_step_o >= -8'sd64 && slice_step_o <= 8'sd63) else $error("slice step out of range");
endmodule // cdr_acq_ctl_properties

bind cdr_acq_ctl cdr_acq_ctl_properties #(.CODE_W(CODE_W), .DLL_W(DLL_W)) u_props (
  .clock_i(clock_i), .rst_i(rst_i), .pd_early_i(pd_early_i), .pd_late_i(pd_late_i),
  .loss_of_lock_flag_o(loss_of_lock_flag_o), .controlled_oscillator_o(controlled_oscillator_o),
  .div_exp_o(div_exp_o), .fll_active_o(fll_active_o), .dll_phase_o(dll_phase_o),
  .dll_slew_o(dll_slew_o), .transfer_bandwidth_scale_o(transfer_bandwidth_scale_o),
  .slice_step_o(slice_step_o));

// >>> tb/cdr_frequency_acquisition_ctl_tb_top.sv
// self-checking bench: two-wire master, field table, phase pulses, lock
// assumes the device answers at two-wire address 7'h40
`timescale 1ns/1ps
module cdr_frequency_acquisition_ctl_tb_top;
  logic              clock_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              scl = 1'b1;
  logic              sda_m = 1'b1;
  logic              pd_early = 1'b0;
  logic              pd_late = 1'b0;
  logic              pd_rise = 1'b0;
  logic [6:0]        trim = 7'h2a;
  logic [7:0]        period = 8'h09;
  logic              sda, sda_o, sda_oe, dtick, stick, loss_of_lock_flag, fll, en, ext, adapt;
  logic [9:0]        code;
  logic [7:0]        dll;
  logic [2:0]        div, bw;
  logic [1:0]        edge_sel, slew;
  logic signed [3:0] phase;
  logic signed [7:0] step;
  logic [21:0]       obs;
  int                err_count = 0;
  int                compares = 0;
  int                cyc = 0;
  // host side: adaptive slice cleared first, slew 0 allowed, never bandwidth 0
  // host writes
  logic [15:0] wrs [11] = '{16'h1302, 16'h1501, 16'h15ff, 16'h1580, 16'h100b, 16'h1017,
                            16'h1408, 16'h1380, 16'h1407, 16'h7355, 16'h21ff};
  logic [21:0] exps [11] = '{22'h090200, 22'h0902c1, 22'h09033f, 22'h0901c0, 22'h1701c0,
                             22'h2f01c0, 22'h2f21c0, 22'h2e61c0, 22'h2e5dc0, 22'h2e5dc0,
                             22'h2e5dc0};
  assign sda = sda_m & ~sda_oe;
  assign obs = {edge_sel, bw, slew, adapt, phase, en, ext, step};
  always #12.5 clock_i = ~clock_i;
  cdr_acq_ctl #(.WIN_BITS(6)) u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .trim_offset_i(trim), .sample_tick_i(stick), .data_tick_i(dtick),
    .pd_early_i(pd_early), .pd_late_i(pd_late), .pd_rise_i(pd_rise),
    .loss_of_lock_flag_o(loss_of_lock_flag), .controlled_oscillator_o(code), .div_exp_o(div),
    .fll_active_o(fll), .dll_phase_o(dll), .edge_sel_o(edge_sel), .dll_slew_o(slew),
    .sample_phase_o(phase), .transfer_bandwidth_scale_o(bw), .slice_enable_o(en),
    .slice_extended_o(ext), .slice_step_o(step), .adaptive_slice_o(adapt));
  cdr_nrz_source u_src (
    .clock_i(clock_i), .osc_code_i(code), .div_exp_i(div), .period_i(period),
    .data_tick_o(dtick), .sample_tick_o(stick));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
    compares++;
    if (a !== e) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, m, a, e);
    end
  endtask
  task automatic sc(input logic s, input logic c);
    sda_m = s;
    scl = c;
    repeat (5) @(negedge clock_i);
  endtask
  task automatic bx(input logic b, output logic r);
    sc(b, 1'b0);
    sc(b, 1'b1);
    r = sda;
    sc(b, 1'b0);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bx(d[i], q[i]);
  endtask
  task automatic st();
    sc(1'b1, 1'b0);
    sc(1'b1, 1'b1);
    sc(1'b0, 1'b1);
    sc(1'b0, 1'b0);
  endtask
  task automatic sp();
    sc(1'b0, 1'b0);
    sc(1'b0, 1'b1);
    sc(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] q0, q1, q2;
    st();
    xfer({8'h80, 1'b1}, q0);
    xfer({a, 1'b1}, q1);
    xfer({d, 1'b1}, q2);
    sp();
    chk(32'({q0[0], q1[0]}), 32'h0, "write not acked");
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] q;
    st();
    xfer({8'h80, 1'b1}, q);
    xfer({a, 1'b1}, q);
    st();
    xfer({8'h81, 1'b1}, q);
    xfer(9'h1ff, q);
    sp();
    d = q[8:1];
  endtask
  task automatic wait_lol(input logic v);
    int n;
    n = 0;
    while (loss_of_lock_flag !== v && n < 40000) begin
      @(negedge clock_i);
      n++;
    end
    chk(32'(loss_of_lock_flag), 32'(v), "lock flag wait");
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    logic [8:0]  q;
    logic [7:0]  d;
    logic [31:0] p;
    repeat (9) @(negedge clock_i);
    chk(32'({loss_of_lock_flag, fll, div, bw, slew}), 32'h312, "reset outputs");
    chk(32'(obs), 32'h094200, "reset fields");
    @(negedge clock_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      wr(wrs[i][15:8], wrs[i][7:0]);
      chk(32'(obs), 32'(exps[i]), "field row");
    end
    $display("test field table done");
    rd(8'h73, d);
    chk(32'(d), 32'({1'b0, trim}), "trim readback");
    rd(8'h15, d);
    chk(32'(d), 32'h80, "threshold readback");
    rd(8'h30, d);
    chk(32'(d), 32'h0, "unmapped read");
    st();
    xfer({8'h90, 1'b1}, q);
    sp();
    chk(32'(q[0]), 32'h1, "foreign address acked");
    $display("test reads done");
    p = 32'(dll);
    pd_late = 1'b1;
    @(negedge clock_i);
    chk(32'(dll), 32'(8'(p - 32'd1)), "late step");
    pd_late = 1'b0;
    pd_early = 1'b1;
    @(negedge clock_i);
    chk(32'(dll), p, "early step");
    pd_late = 1'b1;
    pd_rise = 1'b1;
    @(negedge clock_i);
    pd_late = 1'b0;
    pd_early = 1'b0;
    chk(32'(dll), p, "both no step");
    $display("test phase pulses done");
    wait_lol(1'b0);
    chk(32'({fll, div}), 32'h2, "lock at octave two");
    period = 8'h05;
    wait_lol(1'b1);
    repeat (2) @(negedge clock_i);
    chk(32'({div, code}), 32'h0, "restart at bottom");
    wait_lol(1'b0);
    chk(32'({fll, div}), 32'h1, "relock at octave one");
    $display("test acquisition done");
    tally_and_finish();
  end
endmodule // cdr_frequency_acquisition_ctl_tb_top

// >>> tb/cdr_nrz_source.sv
// far side model: serial data rate ticks and the sampling oscillator
// assumes oscillator rate rises linearly with the control word
`timescale 1ns/1ps
module cdr_nrz_source #(
  parameter int CODE_W = 10
) (
  // clock
  input  wire logic              clock_i,
  // oscillator control and data rate
  input  wire logic [CODE_W-1:0] osc_code_i,
  input  wire logic [2:0]        div_exp_i,
  input  wire logic [7:0]        period_i,
  // ticks
  output logic                   data_tick_o,
  output logic                   sample_tick_o
);
  logic [11:0] acc_reg = '0;
  logic [7:0]  dcnt_reg = '0;
  logic [7:0]  scnt_reg = '0;
  logic [12:0] sum;
  // rate is (1024 + code) / 4096 per clock, then divided by 2**div
  assign sum = {1'b0, acc_reg} + 13'h400 + 13'(osc_code_i);
  initial data_tick_o = 1'b0;
  initial sample_tick_o = 1'b0;
  always_ff @(posedge clock_i) begin
    acc_reg       <= sum[11:0];
    scnt_reg      <= scnt_reg + 8'(sum[12]);
    sample_tick_o <= sum[12] && ((scnt_reg & ((8'h01 << div_exp_i) - 8'h01)) == 8'h00);
  end
  always_ff @(posedge clock_i) begin
    dcnt_reg    <= (dcnt_reg + 8'h01 >= period_i) ? 8'h00 : dcnt_reg + 8'h01;
    data_tick_o <= (dcnt_reg == 8'h00);
  end
endmodule // cdr_nrz_source
